/* rtl/cdsr_regs.sv */
// Diagnostic status registers: general status, over-temperature and open-load in ON state
`default_nettype none
module cdsr_regs #(
  parameter int PWM_LOW_SET_CYC   = cdsr_pkg::PWM_LOW_SET_CYC,
  parameter int PWM_LOW_CLR_CYC   = cdsr_pkg::PWM_LOW_CLR_CYC,
  parameter int FALLBACK_BULB_CYC = cdsr_pkg::FALLBACK_BULB_CYC,
  parameter int FALLBACK_LED_CYC  = cdsr_pkg::FALLBACK_LED_CYC,
  parameter int SEL_TO_HALF_CYC   = cdsr_pkg::SEL_TO_HALF_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 pwm_clk_pin,
  input  wire logic                 sel_n_pin,
  input  wire logic                 supply_uv_det,
  input  wire logic [3:0]           overtemp_det,
  input  wire logic [3:0]           open_load_det,
  input  wire logic [3:0]           output_channel_on,
  input  wire logic [3:0]           shutdown_recovery_select,
  input  wire logic [3:0]           load_type_select,
  input  wire cdsr_pkg::cdsr_rd_req_s rd_req,
  output cdsr_pkg::cdsr_rd_rsp_s    rd_rsp,
  output logic                      global_error_flag,
  output logic [3:0]                fallback_pwm_tick
);
  localparam int CW = 24;
  localparam int NS = 11;

  logic [NS-1:0] async_bus;
  logic [NS-1:0] sync_bus;
  logic          pwm_s;
  logic          sel_n_s;
  logic          uv_s;
  logic [3:0]    ot_s;
  logic [3:0]    ol_s;

  logic          pwm_prev_ff, sel_prev_ff;
  logic [CW-1:0] per_cnt_ff, nxt_per_cnt;
  logic          pwm_low_ff, nxt_pwm_low;
  logic          pwm_rise, sel_rise;
  logic [CW-1:0] to_cnt_ff, nxt_to_cnt;
  logic          sel_toggle_ff, nxt_sel_toggle;
  logic          uv_ff, nxt_uv;
  logic [CW-1:0] bulb_cnt_ff, nxt_bulb_cnt;
  logic [CW-1:0] led_cnt_ff, nxt_led_cnt;
  logic          bulb_tick, led_tick;
  logic [3:0]    tick_ff, nxt_tick;
  logic [3:0]    ot_ff, nxt_ot;
  logic [3:0]    ol_ff, nxt_ol;
  logic          clr_ot, clr_ol;
  cdsr_pkg::cdsr_rd_rsp_s rsp_ff, nxt_rsp;

  // Pins and analog detectors all cross into the clock domain;
  // select goes in inverted so the cleared synchroniser reads as deselected
  assign async_bus = {pwm_clk_pin, ~sel_n_pin, supply_uv_det, overtemp_det, open_load_det};

  cdsr_sync #(
    .W        (NS)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (async_bus),
    .sync_out (sync_bus)
  );

  assign pwm_s   = sync_bus[10];
  assign sel_n_s = ~sync_bus[9];
  assign uv_s    = sync_bus[8];
  assign ot_s    = sync_bus[7:4];
  assign ol_s    = sync_bus[3:0];

  // Edge detection on the synchronised levels
  assign pwm_rise = pwm_s & ~pwm_prev_ff;
  assign sel_rise = sel_n_s & ~sel_prev_ff;

  // Period measurement; saturates so a stopped clock still counts as low
  always_comb begin
    nxt_per_cnt = per_cnt_ff;
    nxt_pwm_low = pwm_low_ff;
    if (pwm_rise) begin
      nxt_per_cnt = '0;
      if (per_cnt_ff < CW'(PWM_LOW_CLR_CYC)) begin
        nxt_pwm_low = 1'b0;
      end
    end else if (per_cnt_ff != {CW{1'b1}}) begin
      nxt_per_cnt = per_cnt_ff + CW'(1);
    end
    if (per_cnt_ff >= CW'(PWM_LOW_SET_CYC)) begin
      nxt_pwm_low = 1'b1;
    end
  end

  // Timeout toggle runs while select is low, cleared on its rising edge
  always_comb begin
    nxt_to_cnt     = to_cnt_ff;
    nxt_sel_toggle = sel_toggle_ff;
    if (sel_rise) begin
      nxt_to_cnt     = '0;
      nxt_sel_toggle = 1'b0;
    end else if (!sel_n_s) begin
      if (to_cnt_ff == CW'(SEL_TO_HALF_CYC - 1)) begin
        nxt_to_cnt     = '0;
        nxt_sel_toggle = ~sel_toggle_ff;
      end else begin
        nxt_to_cnt = to_cnt_ff + CW'(1);
      end
    end
  end

  // Hysteresis lives in the analog detector, so the flag just follows it
  always_comb begin
    nxt_uv = uv_s;
  end

  // Internal fallback clocks, counting only while the external clock is low
  assign bulb_tick = (bulb_cnt_ff == CW'(FALLBACK_BULB_CYC - 1));
  assign led_tick  = (led_cnt_ff == CW'(FALLBACK_LED_CYC - 1));

  always_comb begin
    nxt_bulb_cnt = '0;
    nxt_led_cnt  = '0;
    if (pwm_low_ff) begin
      nxt_bulb_cnt = bulb_tick ? '0 : bulb_cnt_ff + CW'(1);
      nxt_led_cnt  = led_tick ? '0 : led_cnt_ff + CW'(1);
    end
  end

  // Read decode: clear strobes follow the read that reports the bits
  assign clr_ot = rd_req.en & rd_req.clr & (rd_req.addr == cdsr_pkg::ADDR_OVERTEMP_FAULT);
  assign clr_ol = rd_req.en & rd_req.clr & (rd_req.addr == cdsr_pkg::ADDR_OPEN_LOAD_ON);

  // Per-channel fault bits; a detection in the clear cycle survives it
  genvar ch;
  generate
    for (ch = 0; ch < cdsr_pkg::NUM_CH; ch++) begin : g_ch
      always_comb begin
        nxt_tick[ch] = pwm_low_ff & (load_type_select[ch] ? led_tick : bulb_tick);
        if (shutdown_recovery_select[ch]) begin
          nxt_ot[ch] = ot_s[ch];
        end else begin
          nxt_ot[ch] = ot_s[ch] | (ot_ff[ch] & ~clr_ot);
        end
        if (output_channel_on[ch]) begin
          nxt_ol[ch] = ol_s[ch];
        end else begin
          nxt_ol[ch] = ol_ff[ch] & ~clr_ol;
        end
      end
    end
  endgenerate

  // Read answer carries the value sampled before the clear lands
  always_comb begin
    nxt_rsp       = '0;
    nxt_rsp.valid = rd_req.en;
    if (rd_req.en) begin
      case (rd_req.addr)
        cdsr_pkg::ADDR_GENERAL_STATUS: begin
          nxt_rsp.data[cdsr_pkg::POS_PWM_LOW]    = pwm_low_ff;
          nxt_rsp.data[cdsr_pkg::POS_SEL_TOGGLE] = sel_toggle_ff;
          nxt_rsp.data[cdsr_pkg::POS_SUPPLY_UV]  = uv_ff;
        end
        cdsr_pkg::ADDR_OVERTEMP_FAULT: begin
          nxt_rsp.data = {4'h0, ot_ff};
        end
        cdsr_pkg::ADDR_OPEN_LOAD_ON: begin
          nxt_rsp.data = {4'h0, ol_ff};
        end
        default: begin
          nxt_rsp.data = 8'h00;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_prev_ff   <= 1'b0;
      sel_prev_ff   <= 1'b1; // Idle level, so no false edge after reset
      per_cnt_ff    <= '0;
      pwm_low_ff    <= cdsr_pkg::RST_GENERAL_STATUS[cdsr_pkg::POS_PWM_LOW];
      to_cnt_ff     <= '0;
      sel_toggle_ff <= cdsr_pkg::RST_GENERAL_STATUS[cdsr_pkg::POS_SEL_TOGGLE];
      uv_ff         <= cdsr_pkg::RST_GENERAL_STATUS[cdsr_pkg::POS_SUPPLY_UV];
      bulb_cnt_ff   <= '0;
      led_cnt_ff    <= '0;
      tick_ff       <= 4'h0;
      ot_ff         <= cdsr_pkg::RST_OVERTEMP_FAULT[3:0];
      ol_ff         <= cdsr_pkg::RST_OPEN_LOAD_ON[3:0];
      rsp_ff        <= '0;
    end else begin
      pwm_prev_ff   <= pwm_s;
      sel_prev_ff   <= sel_n_s;
      per_cnt_ff    <= nxt_per_cnt;
      pwm_low_ff    <= nxt_pwm_low;
      to_cnt_ff     <= nxt_to_cnt;
      sel_toggle_ff <= nxt_sel_toggle;
      uv_ff         <= nxt_uv;
      bulb_cnt_ff   <= nxt_bulb_cnt;
      led_cnt_ff    <= nxt_led_cnt;
      tick_ff       <= nxt_tick;
      ot_ff         <= nxt_ot;
      ol_ff         <= nxt_ol;
      rsp_ff        <= nxt_rsp;
    end
  end

  // Either supply or clock trouble raises the global error
  assign global_error_flag = pwm_low_ff | uv_ff;
  assign fallback_pwm_tick = tick_ff;
  assign rd_rsp            = rsp_ff;

  // Counters must fit the counts they serve
  initial begin
    if (PWM_LOW_SET_CYC < 2 || PWM_LOW_CLR_CYC < 1 || PWM_LOW_CLR_CYC >= PWM_LOW_SET_CYC)
      $error("cdsr_regs: bad PWM clock thresholds");
    if (FALLBACK_BULB_CYC < 2 || FALLBACK_LED_CYC < 2 || SEL_TO_HALF_CYC < 1)
      $error("cdsr_regs: bad divider counts");
    if (FALLBACK_BULB_CYC >= (1 << CW) || SEL_TO_HALF_CYC >= (1 << CW))
      $error("cdsr_regs: count exceeds counter width");
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_pwm_low_set: assert property (
    (per_cnt_ff >= CW'(PWM_LOW_SET_CYC)) |=> pwm_low_ff)
    else $error("PWM clock low flag not set after long period");

  chk_pwm_low_clear: assert property (
    (pwm_rise && per_cnt_ff < CW'(PWM_LOW_CLR_CYC) && per_cnt_ff < CW'(PWM_LOW_SET_CYC))
      |=> !pwm_low_ff)
    else $error("PWM clock low flag not cleared after short period");

  chk_global_error: assert property (
    ($rose(uv_ff) || $rose(pwm_low_ff)) |-> global_error_flag)
    else $error("Global error not raised by a status flag");

  chk_uv_follow: assert property (
    $rose(uv_s) |=> uv_ff ##0 global_error_flag)
    else $error("Undervoltage flag did not follow detector");

  chk_sel_zeroed: assert property (
    sel_rise |=> !sel_toggle_ff)
    else $error("Timeout toggle not zeroed on select rising edge");

  chk_sel_toggle: assert property (
    (!sel_rise && !sel_n_s && to_cnt_ff == CW'(SEL_TO_HALF_CYC - 1))
      |=> (sel_toggle_ff != $past(sel_toggle_ff)))
    else $error("Timeout toggle missed a half period");

  chk_ot_latched: assert property (
    (ot_ff[0] && !shutdown_recovery_select[0] && !clr_ot) |=> ot_ff[0] [*1])
    else $error("Latched over-temperature bit lost without clear");

  chk_ot_autorestart: assert property (
    (shutdown_recovery_select[1] && !ot_s[1]) |=> !ot_ff[1])
    else $error("Autorestart over-temperature bit not cleared");

  chk_ol_refresh: assert property (
    output_channel_on[2] |=> (ol_ff[2] == $past(ol_s[2])))
    else $error("Open-load bit not refreshed while channel on");

  chk_ol_frozen: assert property (
    (!output_channel_on[3] && !clr_ol) |=> $stable(ol_ff[3]))
    else $error("Open-load bit changed while channel off");

  chk_rc_order: assert property (
    clr_ol |=> (rd_rsp.valid && rd_rsp.data[3:0] == $past(ol_ff)))
    else $error("Read-and-clear did not report the bits before clearing");

  chk_rsvd_zero: assert property (
    rd_rsp.valid |-> (rd_rsp.data[7:4] == 4'h0))
    else $error("Reserved bits read as non-zero");
endmodule
`default_nettype wire

/* rtl/cdsr_pkg.sv */
// Package of constants and types for the channel diagnostic status registers
`default_nettype none
package cdsr_pkg;
  // Register addresses
  localparam logic [5:0] ADDR_GENERAL_STATUS    = 6'h2f;
  localparam logic [5:0] ADDR_OVERTEMP_FAULT    = 6'h30;
  localparam logic [5:0] ADDR_OPEN_LOAD_ON      = 6'h31;
  // Reset values
  localparam logic [7:0] RST_GENERAL_STATUS     = 8'h00;
  localparam logic [7:0] RST_OVERTEMP_FAULT     = 8'h00;
  localparam logic [7:0] RST_OPEN_LOAD_ON       = 8'h00;
  // Field positions in general_status
  localparam int         POS_PWM_LOW            = 2;
  localparam int         POS_SEL_TOGGLE         = 1;
  localparam int         POS_SUPPLY_UV          = 0;
  // Channel count
  localparam int         NUM_CH                 = 4;
  // Timing figures in their own units
  localparam int         CLK_HZ                 = 125000000;
  localparam int         PWM_LOW_SET_HZ         = 11000;
  localparam int         PWM_LOW_CLR_HZ         = 16000;
  localparam int         FALLBACK_BULB_HZ       = 160;
  localparam int         FALLBACK_LED_HZ        = 320;
  // Cycle counts derived from the clock rate (the two PWM thresholds round down, the two fallback counts divide exactly)
  localparam int         PWM_LOW_SET_CYC        = CLK_HZ / PWM_LOW_SET_HZ;
  localparam int         PWM_LOW_CLR_CYC        = CLK_HZ / PWM_LOW_CLR_HZ;
  localparam int         FALLBACK_BULB_CYC      = CLK_HZ / FALLBACK_BULB_HZ;
  localparam int         FALLBACK_LED_CYC       = CLK_HZ / FALLBACK_LED_HZ;
  // Half period of the chip-select timeout, in cycles
  localparam int         SEL_TO_HALF_CYC        = 4096;

  // Register read request from the serial frame decoder
  typedef struct packed {
    logic       en;
    logic       clr;
    logic [5:0] addr;
  } cdsr_rd_req_s;

  // Read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cdsr_rd_rsp_s;
endpackage
`default_nettype wire

/* rtl/cdsr_sync.sv */
// Two flip-flop synchroniser for a bundle of asynchronous levels
`default_nettype none
module cdsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

  initial begin
    if (W < 1) $error("cdsr_sync: width must be at least one");
  end
endmodule
`default_nettype wire

/* tb/cdsr_host_model.sv */
// Host side model: issues register reads and read-and-clear commands
`default_nettype none
module cdsr_host_model (
  input  wire logic                   clk_sys,
  output cdsr_pkg::cdsr_rd_req_s      rd_req,
  input  wire cdsr_pkg::cdsr_rd_rsp_s rd_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rd_req = '0;
  // One request per call; answer taken 1 ns after the edge that takes the request
  task automatic rd(input logic [5:0] addr, input logic clr, output logic [8:0] rsp);
    @(posedge clk_sys);
    rd_req <= '{en: 1'b1, clr: clr, addr: addr};
    @(posedge clk_sys);
    rd_req <= '0;
    // Sample after the answering edge has settled
    #1;
    rsp = {rd_rsp.valid, rd_rsp.data};
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the diagnostic status registers
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_sys, rst_n, pwm_clk_pin, sel_n_pin, supply_uv_det, pwm_run;
  logic [3:0]             overtemp_det, open_load_det, output_channel_on;
  logic [3:0]             shutdown_recovery_select, load_type_select, fallback_pwm_tick;
  logic                   global_error_flag, tick_en;
  cdsr_pkg::cdsr_rd_req_s rd_req;
  cdsr_pkg::cdsr_rd_rsp_s rd_rsp;
  int                     num_errors, checks, t0, t1;
  cdsr_regs #(.PWM_LOW_SET_CYC(40), .PWM_LOW_CLR_CYC(20), .FALLBACK_BULB_CYC(64),
    .FALLBACK_LED_CYC(32), .SEL_TO_HALF_CYC(16)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .pwm_clk_pin(pwm_clk_pin), .sel_n_pin(sel_n_pin), .supply_uv_det(supply_uv_det),
    .overtemp_det(overtemp_det), .open_load_det(open_load_det),
    .output_channel_on(output_channel_on), .shutdown_recovery_select(shutdown_recovery_select),
    .load_type_select(load_type_select), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .global_error_flag(global_error_flag), .fallback_pwm_tick(fallback_pwm_tick));
  cdsr_host_model host (.clk_sys(clk_sys), .rd_req(rd_req), .rd_rsp(rd_rsp));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // PWM clock at 80 ns, phase offset from the system clock
  initial begin
    pwm_clk_pin = 1'b0;
    #3;
    forever begin
      #40;
      if (pwm_run) pwm_clk_pin <= ~pwm_clk_pin;
    end
  end
  // Fallback tick counters
  always @(posedge clk_sys) begin
    if (tick_en) begin
      t0 <= t0 + 32'(fallback_pwm_tick[0]);
      t1 <= t1 + 32'(fallback_pwm_tick[1]);
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read a register and compare valid plus data
  task automatic rchk(input logic [5:0] a, input logic c, input logic [7:0] exp);
    logic [8:0] r;
    host.rd(a, c, r);
    check($sformatf("reg %h", a), {1'b1, exp}, r);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(20000 * 8);
    num_errors++;
    summarize();
  end
  initial begin
    {rst_n, tick_en, supply_uv_det, overtemp_det, open_load_det} = '0;
    {output_channel_on, shutdown_recovery_select, load_type_select} = '0;
    {pwm_run, sel_n_pin} = 2'b11;
    {t0, t1, num_errors, checks} = 128'h0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(60);
    rchk(6'h2f, 1'b0, 8'h00);
    rchk(6'h30, 1'b1, 8'h00);
    rchk(6'h31, 1'b1, 8'h00);
    rchk(6'h3f, 1'b0, 8'h00);
    $display("test reset values done");
    // Latched over-temperature: held until read-and-clear
    overtemp_det <= 4'h5;
    cyc(5);
    overtemp_det <= 4'h0;
    cyc(5);
    rchk(6'h30, 1'b0, 8'h05);
    rchk(6'h30, 1'b1, 8'h05);
    rchk(6'h30, 1'b0, 8'h00);
    // Autorestart: bit follows condition
    shutdown_recovery_select <= 4'ha;
    overtemp_det <= 4'ha;
    cyc(5);
    rchk(6'h30, 1'b0, 8'h0a);
    overtemp_det <= 4'h0;
    cyc(5);
    rchk(6'h30, 1'b0, 8'h00);
    $display("test overtemp done");
    // Open load: refreshed while on, frozen while off
    output_channel_on <= 4'hf;
    open_load_det <= 4'h9;
    cyc(5);
    rchk(6'h31, 1'b0, 8'h09);
    rchk(6'h31, 1'b1, 8'h09);
    rchk(6'h31, 1'b0, 8'h09);
    output_channel_on <= 4'h0;
    open_load_det <= 4'h0;
    cyc(5);
    rchk(6'h31, 1'b0, 8'h09);
    rchk(6'h31, 1'b1, 8'h09);
    rchk(6'h31, 1'b0, 8'h00);
    $display("test open load done");
    // Undervoltage follows detector
    supply_uv_det <= 1'b1;
    cyc(5);
    check("err", 9'h1, {8'h0, global_error_flag});
    rchk(6'h2f, 1'b0, 8'h01);
    supply_uv_det <= 1'b0;
    cyc(5);
    rchk(6'h2f, 1'b0, 8'h00);
    $display("test undervoltage done");
    // Chip-select timeout toggle
    sel_n_pin <= 1'b0;
    cyc(22);
    rchk(6'h2f, 1'b0, 8'h02);
    cyc(16);
    rchk(6'h2f, 1'b0, 8'h00);
    cyc(12);
    sel_n_pin <= 1'b1;
    cyc(6);
    rchk(6'h2f, 1'b0, 8'h00);
    $display("test select timeout done");
    // PWM clock lost: flag, error and fallback ticks
    load_type_select <= 4'h1;
    pwm_run <= 1'b0;
    cyc(60);
    check("err", 9'h1, {8'h0, global_error_flag});
    rchk(6'h2f, 1'b0, 8'h04);
    tick_en <= 1'b1;
    cyc(640);
    tick_en <= 1'b0;
    check("led", 9'h1, {8'h0, t0 >= 19 && t0 <= 21});
    check("bulb", 9'h1, {8'h0, t1 >= 9 && t1 <= 11});
    pwm_run <= 1'b1;
    cyc(60);
    rchk(6'h2f, 1'b0, 8'h00);
    check("err", 9'h0, {8'h0, global_error_flag});
    $display("test pwm clock low done");
    summarize();
  end
endmodule
`default_nettype wire
